// [core/option_byte_config_decode.sv]
// option byte store, programming access and decode of static configuration
`timescale 1ns/10ps

module option_byte_config_decode
    import option_cfg_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    // programming port
    input wire logic PROG_MODE_I,
    input wire logic PROG_WRITE_I,
    input wire logic PROG_ERASE_I,
    input wire logic PROG_SEL_HIGH_I,
    input wire logic [7:0] PROG_WDATA_I,
    output logic [7:0] PROG_RDATA_O,
    output logic PROG_REFUSED_O,
    output logic MEM_ERASE_O,
    // decoded configuration
    output option_cfg_pkg::startup_clock_type STARTUP_CLOCK_SELECT_O,
    output option_cfg_pkg::threshold_type LOW_VOLTAGE_THRESHOLD_SELECT_O,
    output logic LVD_ENABLE_O,
    output logic WATCHDOG_HW_ENABLE_O,
    output logic WATCHDOG_HALT_RESET_O,
    output logic WAKEUP_CLOCK_SELECT_O,
    output option_cfg_pkg::osc_range_type OSCILLATOR_RANGE_O,
    output logic OSC_RANGE_VALID_O,
    output logic RC_DELAY_ACTIVE_O,
    output option_cfg_pkg::block_size_type FIRST_BLOCK_SIZE_O,
    output logic READOUT_PROTECT_O,
    output logic WRITE_PROTECT_O,
    output logic FLASH_WRITE_BLOCK_O
);
    import option_cfg_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [7:0] wdata1;
    logic [7:0] wdata2;
    logic prog_mode;
    logic wr_lvl;
    logic er_lvl;
    logic wr_d;
    logic er_d;
    logic sel_high;

    // two stages on every pin: the tool runs off a clock of its own
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {PROG_MODE_I, PROG_WRITE_I, PROG_ERASE_I, PROG_SEL_HIGH_I};
            sync2 <= sync1;
        end
    end

    // data is used only a strobe later, so skew between its bits is harmless
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            wdata1 <= 8'h00;
            wdata2 <= 8'h00;
        end else begin
            wdata1 <= PROG_WDATA_I;
            wdata2 <= wdata1;
        end
    end

    assign prog_mode = sync2[3];
    assign wr_lvl = sync2[2];
    assign er_lvl = sync2[1];
    assign sel_high = sync2[0];

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            wr_d <= 1'b0;
            er_d <= 1'b0;
        end else begin
            wr_d <= wr_lvl;
            er_d <= er_lvl;
        end
    end

    // write and erase act once per strobe, only in programming mode
    logic wr_pulse;
    logic er_pulse;
    assign wr_pulse = wr_lvl && !wr_d && prog_mode;
    assign er_pulse = er_lvl && !er_d && prog_mode;

    // ------------------------------------------------------------
    // non-volatile option store
    // ------------------------------------------------------------
    // the cells survive a reset like flash: they start at the shipped values
    // and only the programming port changes them, never the reset pin
    logic [7:0] opt_low = LOW_BYTE_DEFAULT;
    logic [7:0] opt_high = HIGH_BYTE_DEFAULT;
    logic locked;
    logic refused;
    logic mem_erase;

    assign locked = opt_low[WRITE_PROT_POS];

    // a set write protect bit freezes both bytes, itself included
    always_ff @(posedge SYS_CLK_I) begin
        if (!locked && er_pulse && !sel_high) begin
            opt_low <= ERASED_BYTE;
        end else if (!locked && wr_pulse && !sel_high) begin
            opt_low <= wdata2;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!locked && er_pulse && sel_high) begin
            opt_high <= ERASED_BYTE;
        end else if (!locked && wr_pulse && sel_high) begin
            opt_high <= wdata2;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            refused <= 1'b0;
        end else begin
            refused <= (wr_pulse || er_pulse) && locked;
        end
    end

    // the whole-memory erase goes out in the same step as the byte erase
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mem_erase <= 1'b0;
        end else begin
            mem_erase <= er_pulse && !locked && opt_low[READOUT_POS];
        end
    end

    assign PROG_REFUSED_O = refused;
    assign MEM_ERASE_O = mem_erase;

    // read back only in programming mode, readout protection does not block it
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            PROG_RDATA_O <= 8'h00;
        end else if (!prog_mode) begin
            PROG_RDATA_O <= 8'h00;
        end else begin
            PROG_RDATA_O <= sel_high ? opt_high : opt_low;
        end
    end

    // ------------------------------------------------------------
    // configuration latched at reset release
    // ------------------------------------------------------------
    // loaded on the first edge after reset, then frozen so that programming
    // changes take effect only after the next reset
    logic loaded;
    logic [7:0] cfg_low;
    logic [7:0] cfg_high;
    logic lvd_enable;
    logic watchdog_hw_enable;
    logic osc_range_valid;
    logic rc_delay_active;
    logic flash_write_block;

    // derived flags are registered too, so no output carries decode glitches
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            loaded <= 1'b0;
            cfg_low <= LOW_BYTE_DEFAULT;
            cfg_high <= HIGH_BYTE_DEFAULT;
            lvd_enable <= (HIGH_BYTE_DEFAULT[THRESHOLD_POS +: 2] != 2'h3);
            watchdog_hw_enable <= !HIGH_BYTE_DEFAULT[WDG_TYPE_POS];
            osc_range_valid <= HIGH_BYTE_DEFAULT[STARTUP_CLK_POS + 1];
            rc_delay_active <= !HIGH_BYTE_DEFAULT[STARTUP_CLK_POS + 1];
            flash_write_block <= LOW_BYTE_DEFAULT[READOUT_POS] || LOW_BYTE_DEFAULT[WRITE_PROT_POS];
        end else if (!loaded) begin
            loaded <= 1'b1;
            cfg_low <= opt_low;
            cfg_high <= opt_high;
            lvd_enable <= (opt_high[THRESHOLD_POS +: 2] != 2'h3);
            watchdog_hw_enable <= !opt_high[WDG_TYPE_POS];
            osc_range_valid <= opt_high[STARTUP_CLK_POS + 1];
            rc_delay_active <= !opt_high[STARTUP_CLK_POS + 1];
            flash_write_block <= opt_low[READOUT_POS] || opt_low[WRITE_PROT_POS];
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign STARTUP_CLOCK_SELECT_O = startup_clock_type'(cfg_high[STARTUP_CLK_POS +: 2]);
    assign LOW_VOLTAGE_THRESHOLD_SELECT_O = threshold_type'(cfg_high[THRESHOLD_POS +: 2]);
    assign LVD_ENABLE_O = lvd_enable;
    assign WATCHDOG_HW_ENABLE_O = watchdog_hw_enable;
    assign WATCHDOG_HALT_RESET_O = cfg_high[WATCHDOG_HALT_RESET_POS];
    assign WAKEUP_CLOCK_SELECT_O = cfg_low[WAKEUP_CLK_POS];
    assign OSCILLATOR_RANGE_O = osc_range_type'(cfg_low[OSC_RANGE_POS +: 3]);
    assign OSC_RANGE_VALID_O = osc_range_valid;
    assign RC_DELAY_ACTIVE_O = rc_delay_active;
    assign FIRST_BLOCK_SIZE_O = block_size_type'(cfg_low[BLOCK_SIZE_POS +: 2]);
    assign READOUT_PROTECT_O = cfg_low[READOUT_POS];
    assign WRITE_PROTECT_O = cfg_low[WRITE_PROT_POS];
    assign FLASH_WRITE_BLOCK_O = flash_write_block;

endmodule

// [pkg/option_cfg_pkg.sv]
// constants and types for the option byte configuration decoder
package option_cfg_pkg;

    // ------------------------------------------------------------
    // byte layout and erased values
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] LOW_BYTE_DEFAULT = 8'hfc;
    localparam logic [7:0] HIGH_BYTE_DEFAULT = 8'h3f;
    // high byte fields
    localparam int STARTUP_CLK_POS = 6;
    localparam int RESERVED_POS = 4;
    localparam int THRESHOLD_POS = 2;
    localparam int WDG_TYPE_POS = 1;
    localparam int WATCHDOG_HALT_RESET_POS = 0;
    // low byte fields
    localparam int WAKEUP_CLK_POS = 7;
    localparam int OSC_RANGE_POS = 4;
    localparam int BLOCK_SIZE_POS = 2;
    localparam int READOUT_POS = 1;
    localparam int WRITE_PROT_POS = 0;
    localparam logic [2:0] OSC_RANGE_LOW_POWER = 3'h4;
    // internal rc startup delay in cycles
    localparam int RC_STARTUP_DELAY = 256;

    // ------------------------------------------------------------
    // decoded settings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_INTERNAL_RC, CLK_WAKEUP_RC, CLK_RESONATOR, CLK_EXTERNAL
    } startup_clock_type;
    typedef enum logic [1:0] {
        LVD_LOWEST, LVD_MEDIUM, LVD_HIGHEST, LVD_OFF
    } threshold_type;
    typedef enum logic [2:0] {
        RANGE_1_2MHZ, RANGE_2_4MHZ, RANGE_4_8MHZ, RANGE_8_16MHZ,
        RANGE_32KHZ, RANGE_EXT_A, RANGE_RESERVED, RANGE_EXT_B
    } osc_range_type;
    typedef enum logic [1:0] {
        SIZE_0K5, SIZE_1K, SIZE_2K, SIZE_4K
    } block_size_type;

endpackage

// [tb/option_byte_config_decode_tb_top.sv]
// testbench for the option byte decoder
`timescale 1ns/10ps
module option_byte_config_decode_tb_top;
    import option_cfg_pkg::*;
    logic SYS_CLK_I = 1'b0, RESETN_I = 1'b0, PROG_MODE_I, PROG_WRITE_I, PROG_ERASE_I, PROG_SEL_HIGH_I;
    logic [7:0] PROG_WDATA_I, PROG_RDATA_O, rd, d;
    logic PROG_REFUSED_O, MEM_ERASE_O, LVD_ENABLE_O, WATCHDOG_HW_ENABLE_O, WATCHDOG_HALT_RESET_O, er;
    logic WAKEUP_CLOCK_SELECT_O, OSC_RANGE_VALID_O, RC_DELAY_ACTIVE_O, READOUT_PROTECT_O, WRITE_PROTECT_O;
    logic FLASH_WRITE_BLOCK_O;
    startup_clock_type STARTUP_CLOCK_SELECT_O;
    threshold_type LOW_VOLTAGE_THRESHOLD_SELECT_O;
    osc_range_type OSCILLATOR_RANGE_O;
    block_size_type FIRST_BLOCK_SIZE_O;
    int n_mismatch = 0, tests_run = 0, lo = 8'hfc, hi = 8'h3f, refd, locked, n_erase = 0, exp_erase = 0;
    always #20 SYS_CLK_I = ~SYS_CLK_I;
    always @(posedge SYS_CLK_I) if (MEM_ERASE_O === 1'b1) n_erase++;
    option_byte_config_decode u_option_byte_config_decode (.*);
    prog_tool u_prog_tool (.*);
    task automatic chk(input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp) $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        if (seen !== exp) n_mismatch++;
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_cfg(input int l, h);
        chk(8'(STARTUP_CLOCK_SELECT_O), 8'(h[7:6]));
        chk({LVD_ENABLE_O, 5'h0, LOW_VOLTAGE_THRESHOLD_SELECT_O}, {h[3:2] != 2'h3, 5'h0, h[3:2]});
        chk({WATCHDOG_HW_ENABLE_O, WATCHDOG_HALT_RESET_O}, {!h[1], h[0]});
        chk({WAKEUP_CLOCK_SELECT_O, OSCILLATOR_RANGE_O}, 8'(l[7:4]));
        chk({OSC_RANGE_VALID_O, RC_DELAY_ACTIVE_O, FLASH_WRITE_BLOCK_O}, {h[7], !h[7], l[1] | l[0]});
        chk({FIRST_BLOCK_SIZE_O, READOUT_PROTECT_O, WRITE_PROTECT_O}, 8'(l[3:0]));
    endtask
    initial begin
        void'($urandom(77237));
        repeat (10) @(posedge SYS_CLK_I);
        RESETN_I <= 1'b1;
        repeat (3) @(posedge SYS_CLK_I);
        chk_cfg(8'hfc, 8'h3f);
        // an erase outside programming mode would lock the low byte
        u_prog_tool.op(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, refd, rd);
        chk(rd, 8'h00);
        chk(8'(refd), 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom());
            // low byte writes keep the lock open and turn readout protection on
            if (!i[0]) d = (d & 8'hfe) | 8'h02;
            er = (i == 4 || i == 5 || i == 7);
            locked = lo[0];
            exp_erase += (!locked && er && lo[1]);
            u_prog_tool.op(1'b1, i[0], !er, er, d, refd, rd);
            if (!locked && er && i[0]) hi = 8'hff;
            else if (!locked && er) lo = 8'hff;
            else if (!locked && i[0]) hi = d | 8'h30;
            else if (!locked) lo = d | 8'hf0;
            chk(rd, 8'(i[0] ? hi : lo));
            chk(8'(refd), 8'(locked));
        end
        chk(8'(n_erase), 8'(exp_erase));
        // a write outside programming mode is dropped without a refusal
        u_prog_tool.op(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, refd, rd);
        chk(rd, 8'h00);
        chk(8'(refd), 8'h00);
        chk_cfg(8'hfc, 8'h3f);
        RESETN_I <= 1'b0;
        repeat (3) @(posedge SYS_CLK_I);
        RESETN_I <= 1'b1;
        repeat (3) @(posedge SYS_CLK_I);
        chk_cfg(lo, hi);
        give_verdict();
    end
    initial begin
        repeat (3000) @(posedge SYS_CLK_I);
        n_mismatch++;
        give_verdict();
    end
endmodule

// [tb/option_cfg_props.sv]
// assertions on the option byte decoder ports
`timescale 1ns/10ps
module option_cfg_props
    import option_cfg_pkg::*;
(
    input wire logic SYS_CLK_I, input wire logic RESETN_I,
    input wire logic PROG_MODE_I, input wire logic PROG_WRITE_I, input wire logic PROG_ERASE_I,
    input wire logic [7:0] PROG_RDATA_O, input wire logic PROG_REFUSED_O, input wire logic MEM_ERASE_O,
    input wire option_cfg_pkg::startup_clock_type STARTUP_CLOCK_SELECT_O,
    input wire option_cfg_pkg::threshold_type LOW_VOLTAGE_THRESHOLD_SELECT_O,
    input wire logic LVD_ENABLE_O, input wire logic OSC_RANGE_VALID_O, input wire logic RC_DELAY_ACTIVE_O
);
    // strobe age ties a pulse to its cause without fixing the sync depth
    logic [3:0] since_strobe;
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
        if (!RESETN_I) since_strobe <= 4'hf;
        else if (PROG_WRITE_I || PROG_ERASE_I) since_strobe <= 4'h0;
        else if (since_strobe != 4'hf) since_strobe <= since_strobe + 4'h1;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);
    a_cfg_held_static: assert property ($past(RESETN_I, 2) |->
        $stable({STARTUP_CLOCK_SELECT_O, LOW_VOLTAGE_THRESHOLD_SELECT_O})) else $error("config moved");
    a_lvd_enable_map: assert property (LVD_ENABLE_O == (LOW_VOLTAGE_THRESHOLD_SELECT_O != LVD_OFF))
        else $error("lvd enable wrong");
    a_range_valid_map: assert property (OSC_RANGE_VALID_O == STARTUP_CLOCK_SELECT_O[1]
        && RC_DELAY_ACTIVE_O != OSC_RANGE_VALID_O) else $error("range valid wrong");
    a_rdata_idle_zero: assert property (!PROG_MODE_I [*5] |-> PROG_RDATA_O == 8'h00)
        else $error("read data outside mode");
    a_refused_one_cycle: assert property (PROG_REFUSED_O |=> !PROG_REFUSED_O) else $error("long refuse");
    a_erase_one_cycle: assert property (MEM_ERASE_O |=> !MEM_ERASE_O) else $error("long erase");
    a_refused_has_cause: assert property (PROG_REFUSED_O |-> since_strobe <= 4'h6)
        else $error("refuse without strobe");
    a_erase_has_cause: assert property (MEM_ERASE_O |-> since_strobe <= 4'h6)
        else $error("erase without strobe");
    c_refused: cover property (PROG_REFUSED_O);
    c_readback: cover property (PROG_MODE_I && PROG_RDATA_O != 8'h00);
    c_write: cover property (PROG_MODE_I && PROG_WRITE_I);
    c_mem_erase: cover property (MEM_ERASE_O);
endmodule
bind option_byte_config_decode option_cfg_props u_option_cfg_props (.*);

// [tb/prog_tool.sv]
// programming tool model driving the option byte port
`timescale 1ns/10ps
module prog_tool (
    input wire logic SYS_CLK_I, input wire logic PROG_REFUSED_O, input wire logic [7:0] PROG_RDATA_O,
    output logic PROG_MODE_I = 1'b0, output logic PROG_WRITE_I = 1'b0, output logic PROG_ERASE_I = 1'b0,
    output logic PROG_SEL_HIGH_I = 1'b0, output logic [7:0] PROG_WDATA_I = 8'h00
);
    // mode and data settle through the synchroniser before the strobe rises
    task automatic op(input logic mode, sel, wr, er, input logic [7:0] d, output int refused, output logic [7:0] rd);
        refused = 0;
        if (sel) d = d | 8'h30;
        else d = d | 8'hf0;
        @(posedge SYS_CLK_I);
        PROG_MODE_I <= mode;
        PROG_SEL_HIGH_I <= sel;
        PROG_WDATA_I <= d;
        repeat (3) @(posedge SYS_CLK_I);
        PROG_WRITE_I <= wr;
        PROG_ERASE_I <= er;
        repeat (4) @(posedge SYS_CLK_I) refused += PROG_REFUSED_O;
        PROG_WRITE_I <= 1'b0;
        PROG_ERASE_I <= 1'b0;
        repeat (6) @(posedge SYS_CLK_I) refused += PROG_REFUSED_O;
        rd = PROG_RDATA_O;
        PROG_WDATA_I <= ~d;
    endtask
endmodule
